// [rtl/fsp_cfg.svh]
// timing counts, pin codes and layout constants for the flash sector host
// assumes a 250 MHz system clock
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH
`define FSP_CLK_MHZ 250
`define FSP_GLITCH_NS 5
`define FSP_PH_NS 40
`define FSP_PH_CYC (((`FSP_PH_NS * `FSP_CLK_MHZ) + 999) / 1000)
`define FSP_ADDR_W 17
`define FSP_SEC_LSB 12
`define FSP_CMD_UNLOCK1_ADDR 17'h00555
`define FSP_CMD_UNLOCK2_ADDR 17'h002AA
`define FSP_CMD_UNLOCK1_DATA 8'hAA
`define FSP_CMD_UNLOCK2_DATA 8'h55
`define FSP_CMD_AUTOSEL 8'h90
`define FSP_CMD_RESET 8'hF0
`define FSP_ID_MAKER_ADDR 17'h00000
`define FSP_ID_PART_ADDR 17'h00001
`define FSP_ID_PROT_ADDR 17'h00002
`define FSP_PROT_YES 8'h01
`define FSP_PROT_NO 8'h00
`endif

// [rtl/fsp_pkg.sv]
// types shared by the flash sector host
// assumes fsp_cfg.svh for numeric constants
package fsp_pkg;
    typedef enum logic [3:0] {
        FSP_OP_READ = 4'h0,
        FSP_OP_WRITE = 4'h1,
        FSP_OP_ID_HV = 4'h2,
        FSP_OP_ID_CMD = 4'h3,
        FSP_OP_EXIT = 4'h4
    } fsp_op_type;
    typedef enum logic [5:0] {
        FSP_ST_IDLE = 6'b000001,
        FSP_ST_SETUP = 6'b000010,
        FSP_ST_STROBE = 6'b000100,
        FSP_ST_HOLD = 6'b001000,
        FSP_ST_READ = 6'b010000,
        FSP_ST_DONE = 6'b100000
    } fsp_state_type;
endpackage

// [rtl/fsp_sector_map.sv]
// sector index decode from the upper address bits
// assumes a fixed boot layout chosen at build time
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_sector_map #(
    parameter bit TOP_BOOT = 1'b1
) (
    input wire logic [4:0] i_upper,
    output logic [3:0] o_sector
);
    always_comb begin
        if (TOP_BOOT) begin
            // seven 16K, then 4K, 4K, 8K at the top
            if (i_upper[4:2] != 3'b111) begin
                o_sector = {1'b0, i_upper[4:2]};
            end else if (i_upper[1]) begin
                o_sector = 4'h9;
            end else begin
                o_sector = i_upper[0] ? 4'h8 : 4'h7;
            end
        end else begin
            // 8K, 4K, 4K at the bottom, then seven 16K
            if (i_upper[4:2] != 3'b000) begin
                o_sector = 4'h2 + {1'b0, i_upper[4:2]};
            end else if (!i_upper[1]) begin
                o_sector = 4'h0;
            end else begin
                o_sector = i_upper[0] ? 4'h2 : 4'h1;
            end
        end
    end
endmodule

// [rtl/fsp_host.sv]
// host controller that drives the boot-sector flash through its pins
// assumes pins toward the flash; data lines are split in/out/enable
`timescale 1ns/1ps
`include "fsp_cfg.svh"
// Function
// - high voltage id: A6 low, A1 A0
// - protection check: A1 high, A0 low
// - id readable after autoselect command
// - primary method: reset pin high voltage (this host runs no protect or unprotect flow)
// - protect all before first unprotect (this host runs no protect or unprotect flow)
// - alternate method: three pins high voltage (not used here; o_hv_hard_clear is held low)
// - host starts no new cycle below lockout (a cycle already running still completes)
// - write needs select, strobe low, gate high
// - autoselect held until reset command
module fsp_host
    import fsp_pkg::*;
#(
    parameter bit TOP_BOOT = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_req,
    input wire fsp_pkg::fsp_op_type i_op,
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_supply_ok,
    input wire logic [7:0] i_data_lines,
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic [3:0] o_sector,
    output logic o_in_autoselect,
    output logic [16:0] o_addr,
    output logic [7:0] o_data_lines,
    output logic o_data_oe,
    output logic o_chip_select_n,
    output logic o_output_gate_n,
    output logic o_write_strobe_n,
    output logic o_hv_bit_nine,
    output logic o_hv_hard_clear
);
    import fsp_pkg::*;

    fsp_state_type state_q;
    fsp_op_type op_q;
    logic [7:0] tmr_q;
    logic [1:0] step_q;
    logic [1:0] nsteps_q;
    logic [16:0] req_addr_q;
    logic [7:0] req_data_q;
    logic [7:0] din_s1_q;
    logic [7:0] din_s2_q;
    logic sup_s1_q;
    logic sup_s2_q;
    logic [3:0] sector_w;
    logic is_write_w;
    logic tmr_zero_w;

    localparam logic [7:0] PH_CYC = 8'(`FSP_PH_CYC);

    // pin inputs are asynchronous to our clock
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
            sup_s1_q <= 1'b0;
            sup_s2_q <= 1'b0;
        end else begin
            din_s1_q <= i_data_lines;
            din_s2_q <= din_s1_q;
            sup_s1_q <= i_supply_ok;
            sup_s2_q <= sup_s1_q;
        end
    end

    fsp_sector_map #(
        .TOP_BOOT(TOP_BOOT)
    ) u_map (
        .i_upper(i_addr[16:12]),
        .o_sector(sector_w)
    );

    function automatic logic [16:0] step_addr(input fsp_op_type op, input logic [1:0] st,
                                              input logic [16:0] a);
        if (op == FSP_OP_ID_HV) begin
            // bit 6 forced low whatever the caller gave, or the id read is not valid
            step_addr = {a[16:7], 1'b0, a[5:0]};
        end else if (op == FSP_OP_READ || st == 2'd3) begin
            step_addr = a;
        end else if (st == 2'd1) begin
            step_addr = `FSP_CMD_UNLOCK2_ADDR;
        end else begin
            step_addr = `FSP_CMD_UNLOCK1_ADDR;
        end
    endfunction

    function automatic logic [7:0] step_data(input fsp_op_type op, input logic [1:0] st,
                                             input logic [7:0] d);
        case (st)
            2'd0: step_data = (op == FSP_OP_EXIT) ? `FSP_CMD_RESET : `FSP_CMD_UNLOCK1_DATA;
            2'd1: step_data = `FSP_CMD_UNLOCK2_DATA;
            2'd2: step_data = (op == FSP_OP_ID_CMD) ? `FSP_CMD_AUTOSEL : d;
            default: step_data = d;
        endcase
    endfunction

    assign tmr_zero_w = (tmr_q == 8'h00);
    // a command step is a write; the last step of an id op is a read
    assign is_write_w = (op_q == FSP_OP_WRITE) || (op_q == FSP_OP_EXIT) ||
                        ((op_q == FSP_OP_ID_CMD) && (step_q != nsteps_q));

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_q <= FSP_ST_IDLE;
            op_q <= FSP_OP_READ;
            tmr_q <= 8'h00;
            step_q <= 2'd0;
            nsteps_q <= 2'd0;
            req_addr_q <= 17'h00000;
            req_data_q <= 8'h00;
        end else begin
            if (!tmr_zero_w) begin
                tmr_q <= tmr_q - 8'h01;
            end
            case (state_q)
                FSP_ST_IDLE: begin
                    // no new operation starts while the synchronised supply is below lockout; one already running carries on
                    if (i_req && sup_s2_q) begin
                        op_q <= i_op;
                        req_addr_q <= i_addr;
                        req_data_q <= i_wdata;
                        step_q <= 2'd0;
                        // two unlock writes, the command (id) or payload (write) byte at 555, then the step at the caller's address
                        case (i_op)
                            FSP_OP_WRITE: nsteps_q <= 2'd3;
                            FSP_OP_ID_CMD: nsteps_q <= 2'd3;
                            default: nsteps_q <= 2'd0;
                        endcase
                        tmr_q <= PH_CYC;
                        state_q <= FSP_ST_SETUP;
                    end
                end
                FSP_ST_SETUP: begin
                    if (tmr_zero_w) begin
                        tmr_q <= PH_CYC;
                        state_q <= is_write_w ? FSP_ST_STROBE : FSP_ST_READ;
                    end
                end
                FSP_ST_STROBE: begin
                    // strobe held far longer than the glitch filter
                    if (tmr_zero_w) begin
                        tmr_q <= PH_CYC;
                        state_q <= FSP_ST_HOLD;
                    end
                end
                FSP_ST_READ: begin
                    if (tmr_zero_w) begin
                        tmr_q <= PH_CYC;
                        state_q <= FSP_ST_HOLD;
                    end
                end
                FSP_ST_HOLD: begin
                    if (tmr_zero_w) begin
                        if (step_q == nsteps_q) begin
                            state_q <= FSP_ST_DONE;
                        end else begin
                            step_q <= step_q + 2'd1;
                            tmr_q <= PH_CYC;
                            state_q <= FSP_ST_SETUP;
                        end
                    end
                end
                FSP_ST_DONE: begin
                    state_q <= FSP_ST_IDLE;
                end
                default: begin
                    state_q <= FSP_ST_IDLE;
                end
            endcase
        end
    end

    // bus pins; writes only with select and strobe low, gate high
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_chip_select_n <= 1'b1;
            o_output_gate_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_data_oe <= 1'b0;
            o_data_lines <= 8'h00;
            o_addr <= 17'h00000;
        end else begin
            o_addr <= step_addr(op_q, step_q, req_addr_q);
            o_data_lines <= step_data(op_q, step_q, req_data_q);
            // data held past the strobe rise so the early-rise latch sees it
            o_data_oe <= (state_q == FSP_ST_STROBE) ||
                         ((state_q == FSP_ST_HOLD) && is_write_w);
            o_chip_select_n <= !((state_q == FSP_ST_STROBE) || (state_q == FSP_ST_READ));
            // gate stays high on writes, low only on reads
            o_output_gate_n <= (state_q != FSP_ST_READ);
            o_write_strobe_n <= (state_q != FSP_ST_STROBE);
        end
    end

    // elevated-voltage identification keeps bit nine at id level
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_hv_bit_nine <= 1'b0;
            o_hv_hard_clear <= 1'b0;
        end else begin
            o_hv_bit_nine <= (op_q == FSP_OP_ID_HV) && (state_q != FSP_ST_IDLE) &&
                             (state_q != FSP_ST_DONE);
            // never raised: this host runs no protect or unprotect flow, so neither
            // voltage method starts and the three-pin combination cannot arise
            o_hv_hard_clear <= 1'b0;
        end
    end

    // autoselect stays on until the reset command goes out
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_in_autoselect <= 1'b0;
        end else if (state_q == FSP_ST_DONE) begin
            if (op_q == FSP_OP_ID_CMD) begin
                o_in_autoselect <= 1'b1;
            end else if (op_q == FSP_OP_EXIT) begin
                o_in_autoselect <= 1'b0;
            end
        end
    end

    // read data sampled late in the read phase from synchronised pins
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_sector <= 4'h0;
        end else begin
            if (state_q == FSP_ST_HOLD && !is_write_w && tmr_q == PH_CYC) begin
                o_rdata <= din_s2_q;
            end
            o_busy <= (state_q != FSP_ST_IDLE);
            o_done <= (state_q == FSP_ST_DONE);
            if (i_req && state_q == FSP_ST_IDLE) begin
                o_sector <= sector_w;
            end
        end
    end
endmodule

// [test/fsp_host_props.sv]
// pin-level assertions for the flash host
// assumes it is bound onto fsp_host and sees only its ports
`timescale 1ns/1ps
module fsp_host_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [16:0] o_addr,
    input wire logic o_data_oe,
    input wire logic o_chip_select_n,
    input wire logic o_output_gate_n,
    input wire logic o_write_strobe_n,
    input wire logic o_hv_bit_nine,
    input wire logic o_hv_hard_clear
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_wr_on;
        !o_chip_select_n && !o_write_strobe_n;
    endsequence
    sequence s_gate_low;
        !o_output_gate_n [*8];
    endsequence
    a_write_gate_high: assert property (s_wr_on |-> o_output_gate_n && o_data_oe)
        else $error("write strobe without gate high");
    a_gate_no_drive: assert property (!o_output_gate_n |-> !o_data_oe)
        else $error("host drives data while gate low");
    a_strobe_wide: assert property (
        $fell(o_write_strobe_n) |-> !o_write_strobe_n [*8])
        else $error("write strobe too short");
    a_gate_wide: assert property ($fell(o_output_gate_n) |-> s_gate_low)
        else $error("gate pulse too short");
    a_addr_held: assert property (s_wr_on ##1 s_wr_on |-> $stable(o_addr))
        else $error("address moved during strobe");
    a_strobe_selects: assert property (!o_write_strobe_n |-> !o_chip_select_n)
        else $error("strobe without chip select");
    a_hv_id_read: assert property (
        o_hv_bit_nine && !o_output_gate_n |-> o_write_strobe_n && !o_addr[6])
        else $error("bad id read pins");
    a_no_alt_method: assert property (!(o_hv_bit_nine && o_hv_hard_clear))
        else $error("both voltage requests high");
endmodule
bind fsp_host fsp_host_chk u_chk (.i_clk_sys, .i_rst, .o_addr, .o_data_oe, .o_chip_select_n,
    .o_output_gate_n, .o_write_strobe_n, .o_hv_bit_nine, .o_hv_hard_clear);

// [test/fsp_flash_model.sv]
// behavioural boot-sector flash driven through its pins
// assumes registered host pins; one protect flag per 4 Kbyte block
`timescale 1ns/1ps
module fsp_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5A // arbitrary value
) (
    input wire logic [16:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_chip_select_n,
    input wire logic i_output_gate_n,
    input wire logic i_write_strobe_n,
    input wire logic i_hv_bit_nine,
    input wire logic i_hv_hard_clear,
    input wire logic i_supply_ok,
    output logic [7:0] o_data
);
    logic [7:0] mem [0:131071];
    logic [31:0] prot = 32'h0;
    logic [1:0] step = 2'h0;
    logic autosel = 1'b0;
    logic [7:0] last = 8'h00;
    wire wr_act = !i_chip_select_n && !i_write_strobe_n && i_output_gate_n;
    // erased array reads all ones
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'hFF;
        end
    end
    // a released bus shows the inverse of the last byte, so stale data never passes
    always @* begin
        if (i_chip_select_n || i_output_gate_n) begin
            o_data = ~last;
        end else if (i_hv_bit_nine || autosel) begin
            o_data = (i_addr[1:0] == 2'h0) ? MAKER_CODE :
                     (i_addr[1:0] == 2'h1) ? PART_CODE : {7'h00, prot[i_addr[16:12]]};
            last = o_data;
        end else begin
            o_data = mem[i_addr];
            last = o_data;
        end
    end
    // address and data are both settled when the strobe ends
    always @(negedge wr_act) begin
        if (!i_supply_ok || i_data == 8'hF0) begin
            step = 2'h0;
            autosel = 1'b0;
        end else if (step == 2'h3) begin
            // a cleared protect flag lets writes through again
            if (!prot[i_addr[16:12]] || i_hv_hard_clear) begin
                mem[i_addr] = i_data;
            end
            step = 2'h0;
        end else if (step == 2'h2) begin
            autosel = autosel || i_data == 8'h90;
            step = (i_data == 8'hA0) ? 2'h3 : 2'h0;
        end else begin
            step = (step == 2'h0 && i_addr == 17'h00555 && i_data == 8'hAA) ? 2'h1 :
                   (step == 2'h1 && i_addr == 17'h002AA && i_data == 8'h55) ? 2'h2 : 2'h0;
        end
    end
endmodule

// [test/fsp_host_tb.sv]
// self-checking bench: flash host against the pin-level flash model
// assumes design, checker and model compiled before it
`timescale 1ns/1ps
`include "fsp_cfg.svh"
module fsp_host_tb;
    import fsp_pkg::*;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] PART = 8'h5A; // arbitrary value
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_req = 1'b0;
    fsp_op_type i_op = FSP_OP_READ;
    logic [16:0] i_addr = 17'h00000;
    logic [7:0] i_wdata = 8'h00;
    logic i_supply_ok = 1'b1;
    logic o_busy, o_done, o_in_autoselect, o_data_oe, o_chip_select_n, o_output_gate_n;
    logic o_write_strobe_n, o_hv_bit_nine, o_hv_hard_clear;
    logic [7:0] o_rdata, o_data_lines, flash_q;
    logic [3:0] o_sector, bot_sector;
    logic [16:0] o_addr;
    wire [7:0] i_data_lines = o_data_oe ? o_data_lines : flash_q;
    int error_cnt = 0;
    int checks_done = 0;
    initial forever #2 i_clk_sys = ~i_clk_sys;
    fsp_host #(.TOP_BOOT(1'b1)) DUT (.i_clk_sys, .i_rst, .i_req, .i_op, .i_addr, .i_wdata,
        .i_supply_ok, .i_data_lines, .o_busy, .o_done, .o_rdata, .o_sector, .o_in_autoselect,
        .o_addr, .o_data_lines, .o_data_oe, .o_chip_select_n, .o_output_gate_n,
        .o_write_strobe_n, .o_hv_bit_nine, .o_hv_hard_clear);
    // bottom-boot copy runs in lockstep; only its sector index is looked at
    fsp_host #(.TOP_BOOT(1'b0)) dut_bot (.i_clk_sys, .i_rst, .i_req, .i_op, .i_addr,
        .i_wdata, .i_supply_ok, .i_data_lines(flash_q), .o_busy(), .o_done(), .o_rdata(),
        .o_sector(bot_sector), .o_in_autoselect(), .o_addr(), .o_data_lines(), .o_data_oe(),
        .o_chip_select_n(), .o_output_gate_n(), .o_write_strobe_n(), .o_hv_bit_nine(),
        .o_hv_hard_clear());
    fsp_flash_model u_flash (.i_addr(o_addr), .i_data(i_data_lines),
        .i_chip_select_n(o_chip_select_n), .i_output_gate_n(o_output_gate_n),
        .i_write_strobe_n(o_write_strobe_n), .i_hv_bit_nine(o_hv_bit_nine),
        .i_hv_hard_clear(o_hv_hard_clear), .i_supply_ok(i_supply_ok), .o_data(flash_q));
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input fsp_op_type op, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(posedge i_clk_sys);
        i_op <= op;
        i_addr <= a;
        i_wdata <= d;
        i_req <= 1'b1;
        @(posedge i_clk_sys);
        i_req <= 1'b0;
        for (n = 0; n < 600 && o_done !== 1'b1; n++) @(posedge i_clk_sys);
        if (n >= 600) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task automatic t_idle();
        cmp({o_chip_select_n, o_output_gate_n, o_write_strobe_n, o_data_oe}, 4'hE);
        cmp({o_hv_bit_nine, o_hv_hard_clear}, 2'h0);
    endtask
    task automatic t_sectors();
        logic [16:0] tbl [8] = '{17'h00000, 17'h02800, 17'h03123, 17'h05000, 17'h1BFFF,
                                 17'h1C000, 17'h1D7FF, 17'h1E000};
        logic [3:0] top_exp [8] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h6, 4'h7, 4'h8, 4'h9};
        logic [3:0] bot_exp [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'h9, 4'h9};
        foreach (tbl[i]) begin
            run(FSP_OP_READ, tbl[i], 8'h00);
            cmp(o_sector, top_exp[i]);
            cmp(o_rdata, 8'hFF);
            cmp(bot_sector, bot_exp[i]);
        end
    endtask
    task automatic t_ids_hv();
        run(FSP_OP_ID_HV, 17'h00000, 8'h00);
        cmp(o_rdata, MAKER);
        run(FSP_OP_ID_HV, 17'h00001, 8'h00);
        cmp(o_rdata, PART);
        run(FSP_OP_ID_HV, 17'h1C002, 8'h00);
        cmp(o_rdata, 8'h00);
    endtask
    task automatic t_protect();
        u_flash.prot[28] = 1'b1;
        run(FSP_OP_ID_HV, 17'h1C002, 8'h00);
        cmp(o_rdata, 8'h01);
        run(FSP_OP_WRITE, 17'h1C010, 8'hA0);
        run(FSP_OP_READ, 17'h1C010, 8'h00);
        cmp(o_rdata, 8'hFF);
    endtask
    task automatic t_program();
        run(FSP_OP_WRITE, 17'h00010, 8'hA0);
        run(FSP_OP_READ, 17'h00010, 8'h00);
        cmp(o_rdata, 8'hA0);
        run(FSP_OP_WRITE, 17'h00020, 8'h12);
        run(FSP_OP_READ, 17'h00020, 8'h00);
        cmp(o_rdata, 8'hFF);
    endtask
    task automatic t_autoselect();
        run(FSP_OP_ID_CMD, 17'h1C002, 8'h00);
        cmp({o_in_autoselect, o_rdata}, 9'h101);
        run(FSP_OP_READ, 17'h00011, 8'h00);
        cmp(o_rdata, PART);
        run(FSP_OP_EXIT, 17'h00000, 8'h00);
        cmp(o_addr, `FSP_CMD_UNLOCK1_ADDR);
        cmp(o_data_lines, `FSP_CMD_RESET);
        run(FSP_OP_READ, 17'h00010, 8'h00);
        cmp({o_in_autoselect, o_rdata}, 9'h0A0);
    endtask
    task automatic t_supply();
        i_supply_ok <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_req <= 1'b1;
        repeat (40) @(posedge i_clk_sys);
        cmp({o_busy, o_write_strobe_n}, 2'h1);
        i_req <= 1'b0;
        i_supply_ok <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
    endtask
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        t_idle();
        t_sectors();
        t_ids_hv();
        t_protect();
        t_program();
        t_autoselect();
        t_supply();
        tally_and_finish();
    end
endmodule
